// ---- src/ppm_cfg.svh ----
// constants for the power-management and configuration loader block
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH
// register offsets in configuration space
`define PPM_OFS_CAP    8'h40
`define PPM_OFS_CSR    8'h44
`define PPM_OFS_USER   8'h48
// capability word fields
`define PPM_PME_SUP    5'h08
`define PPM_PME_CLK    1'h1
`define PPM_PM_VER     3'h2
`define PPM_NEXT_PTR   8'h00
`define PPM_CAP_ID     8'h01
// control/status field positions
`define PPM_PS_HI      1
`define PPM_PS_LO      0
`define PPM_PME_EN_BIT 8
`define PPM_PME_ST_BIT 15
// power-state encodings
`define PPM_PS_D0      2'h0
`define PPM_PS_D3      2'h3
// reset values
`define PPM_CLASS_RST  24'h070002
`define PPM_USER_RST   32'h00000000
// eeprom organisation and read command
`define PPM_EE_WORDS   3'h7
`define PPM_EE_OP_RD   2'h2
`define PPM_EE_BITS    5'd25
`define PPM_EE_W_VEN   3'h0
`define PPM_EE_W_DEV   3'h1
`define PPM_EE_W_CLO   3'h2
`define PPM_EE_W_CHI   3'h3
`define PPM_EE_W_SVEN  3'h4
`define PPM_EE_W_SID   3'h5
`define PPM_EE_W_ULO   3'h6
`define PPM_EE_W_UHI   3'h7
// timing
`define PPM_CLK_NS     50
`define PPM_WAKE_NS    500
`define PPM_WAKE_CYC   ((`PPM_WAKE_NS + `PPM_CLK_NS - 1) / `PPM_CLK_NS)
`define PPM_LOAD_MAX   65536
`define PPM_SYNC_CYC   2'h2
`endif

// ---- src/ppm_pkg.sv ----
// types shared by the power-management block
package ppm_pkg;
  typedef enum logic [5:0] {
    PPM_ST_STRAP = 6'b000001,
    PPM_ST_LOAD  = 6'b000010,
    PPM_ST_D0U   = 6'b000100,
    PPM_ST_D0A   = 6'b001000,
    PPM_ST_D3    = 6'b010000,
    PPM_ST_WAKE  = 6'b100000
  } ppm_state_t;
  typedef enum logic [2:0] {
    PPM_EE_IDLE  = 3'b001,
    PPM_EE_SHIFT = 3'b010,
    PPM_EE_GAP   = 3'b100
  } ppm_ee_state_t;
endpackage : ppm_pkg

// ---- src/ppm_ee_rd.sv ----
// serial eeprom word reader, three-wire read of one 16-bit word
`timescale 1ns/10ps
`include "ppm_cfg.svh"
// keep SK_HALF at three or more: data-in reaches the shifter two clocks late
module ppm_ee_rd import ppm_pkg::*; #(
  parameter logic [7:0] SK_HALF = 8'h08
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [5:0]  addr_i,
  output logic             done_o,
  output logic [15:0]      data_o,
  output logic             ee_cs_o,
  output logic             ee_sk_o,
  output logic             ee_di_o,
  input  wire logic        ee_do_i
);
  ppm_ee_state_t st, next_st;
  logic [7:0]  div, next_div;
  logic        sk, next_sk;
  logic        cs, next_cs;
  logic        done, next_done;
  logic [4:0]  nbit, next_nbit;
  logic [8:0]  sh_o, next_sh_o;
  logic [15:0] sh_i, next_sh_i;
  logic        do_m, do_s;

  assign done_o  = done;
  assign data_o  = sh_i;
  assign ee_cs_o = cs;
  assign ee_sk_o = sk;
  assign ee_di_o = sh_o[8];

  // next-value logic of the serial sequencer
  always_comb begin
    next_st   = st;
    next_div  = div;
    next_sk   = sk;
    next_cs   = cs;
    next_done = 1'b0;
    next_nbit = nbit;
    next_sh_o = sh_o;
    next_sh_i = sh_i;
    unique case (st)
      PPM_EE_IDLE: begin
        if (start_i) begin
          next_st   = PPM_EE_SHIFT;
          next_cs   = 1'b1;
          next_sh_o = {1'b1, `PPM_EE_OP_RD, addr_i};
          next_nbit = `PPM_EE_BITS;
          next_div  = 8'h00;
          next_sk   = 1'b0;
        end
      end
      PPM_EE_SHIFT: begin
        if (div == SK_HALF - 8'h01) begin
          next_div = 8'h00;
          next_sk  = ~sk;
          if (sk) begin
            next_sh_i = {sh_i[14:0], do_s};
            next_sh_o = {sh_o[7:0], 1'b0};
            next_nbit = nbit - 5'd1;
            if (nbit == 5'd1) begin
              next_st = PPM_EE_GAP;
              next_cs = 1'b0;
            end
          end
        end else begin
          next_div = div + 8'h01;
        end
      end
      PPM_EE_GAP: begin
        // chip select stays low for at least one half period between words
        if (div == SK_HALF - 8'h01) begin
          next_div  = 8'h00;
          next_done = 1'b1;
          next_st   = PPM_EE_IDLE;
        end else begin
          next_div = div + 8'h01;
        end
      end
    endcase
  end

  // registers of the sequencer and the data-in synchroniser
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st   <= PPM_EE_IDLE;
      div  <= 8'h00;
      sk   <= 1'b0;
      cs   <= 1'b0;
      done <= 1'b0;
      nbit <= 5'd0;
      sh_o <= 9'h000;
      sh_i <= 16'h0000;
      do_m <= 1'b0;
      do_s <= 1'b0;
    end else begin
      st   <= next_st;
      div  <= next_div;
      sk   <= next_sk;
      cs   <= next_cs;
      done <= next_done;
      nbit <= next_nbit;
      sh_o <= next_sh_o;
      sh_i <= next_sh_i;
      do_m <= ee_do_i;
      do_s <= do_m;
    end
  end
endmodule : ppm_ee_rd

// ---- src/ppm_pm_top.sv ----
// power-management registers, power states, wake events, eeprom loader
`timescale 1ns/10ps
`include "ppm_cfg.svh"
// Summary of operation
// - power registers are two dwords starting at configuration offset 0x40.
// - capability word reads fixed id, pointer, version and event support.
// - control/status holds power state, event enable, write-one-clear status.
// - data and bridge-extension bytes always read zero.
// - states D0, D3hot, D3cold; event only from D3hot with clock.
// - entering D0 from reset gives uninitialised, software init gives active.
// - active state answers all transactions and may interrupt.
// - D3hot answers configuration only, no memory answer, no interrupt.
// - receive and flow control keep running in D3hot.
// - in D3hot, enabled event on start bit or modem delta bit.
// - event status set on wake event even when not enabled.
// - D3hot to D0 gives active state with context kept.
// - bus drivers stay off during the D3hot to D0 transition.
// - power loss loses context; reset returns everything to defaults.
// - user word at 0x48, reset zero, eeprom-loaded, bus read-only.
// - eeprom is read as 16-bit words.
// - load only when chip-select pin samples high at reset release.
// - download ends within 2^16 clocks of reset release.
// - eeprom words 0..7 map to ids, class, subsystem, user word.
// - class word keeps only its upper byte; revision stays fixed.
module ppm_pm_top import ppm_pkg::*; #(
  parameter int          LOAD_LIMIT = `PPM_LOAD_MAX,
  parameter logic [7:0]  SK_HALF    = 8'h08,
  parameter logic [15:0] VEN_DEF    = 16'h5a5a, // arbitrary value
  parameter logic [15:0] DEV_DEF    = 16'ha5a5  // arbitrary value
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cfg_sel_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic [31:0]      cfg_rdata_o,
  output logic             cfg_ack_o,
  output logic             cfg_retry_o,
  input  wire logic        mem_sel_i,
  output logic             mem_ack_o,
  input  wire logic        mem_enable_i,
  input  wire logic        uart_irq_i,
  output logic             inta_n_o,
  output logic             pci_drv_en_o,
  output logic             rx_run_o,
  input  wire logic [3:0]  rx_pin_i,
  input  wire logic [15:0] msr_delta_i,
  output logic             pme_out_o,
  output logic             pme_oe_o,
  output logic [1:0]       power_state_o,
  output logic [15:0]      vendor_id_o,
  output logic [15:0]      device_id_o,
  output logic [23:0]      class_code_o,
  output logic [15:0]      subsys_ven_o,
  output logic [15:0]      subsys_id_o,
  input  wire logic        eeprom_chip_select_i,
  output logic             eeprom_chip_select_o,
  output logic             eeprom_chip_select_oe_o,
  output logic             ee_sk_o,
  output logic             ee_di_o,
  input  wire logic        ee_do_i
);
  localparam logic [16:0] LOAD_END = 17'(LOAD_LIMIT - 1);
  localparam logic [7:0]  WAKE_END = 8'(`PPM_WAKE_CYC - 1);

  ppm_state_t  st, next_st;
  logic [1:0]  ps, next_ps;
  logic        pme_en, next_pme_en;
  logic        pme_st, next_pme_st;
  logic        pme_oe, next_pme_oe;
  logic [31:0] user_w, next_user_w;
  logic [15:0] ven, next_ven;
  logic [15:0] dev, next_dev;
  logic [23:0] cls, next_cls;
  logic [15:0] sven, next_sven;
  logic [15:0] sid, next_sid;
  logic [2:0]  widx, next_widx;
  logic        ee_go, next_ee_go;
  logic        ee_busy, next_ee_busy;
  logic [16:0] lcnt, next_lcnt;
  logic [7:0]  wcnt, next_wcnt;
  logic [1:0]  scnt, next_scnt;
  logic [31:0] rdata, next_rdata;
  logic        ack, next_ack;
  logic        retry, next_retry;
  logic        mack, next_mack;
  logic        inta_n, next_inta_n;
  logic        drv_en, next_drv_en;
  logic [3:0]  rx_m, rx_s, rx_d;
  logic        cs_m, cs_s;
  logic [15:0] msr_d;
  logic        ee_done, ee_cs;
  logic [15:0] ee_data;
  logic        wake_evt;
  logic        csr_wr;

  // write of one supported power-state code through byte lane 0
  function automatic logic ps_req(input logic wr, input logic [3:0] be,
                                  input logic [1:0] v, input logic [1:0] w);
    ps_req = wr && be[0] && (v == w);
  endfunction : ps_req

  ppm_ee_rd #(
    .SK_HALF (SK_HALF)
  ) u_ee (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (ee_go),
    .addr_i    ({3'h0, widx}),
    .done_o    (ee_done),
    .data_o    (ee_data),
    .ee_cs_o   (ee_cs),
    .ee_sk_o   (ee_sk_o),
    .ee_di_o   (ee_di_o),
    .ee_do_i   (ee_do_i)
  );

  assign eeprom_chip_select_o    = ee_cs;
  assign eeprom_chip_select_oe_o = ee_busy;

  // start bit or modem delta detection
  assign wake_evt = (|(rx_d & ~rx_s)) || (|(msr_delta_i & ~msr_d));
  assign csr_wr   = cfg_sel_i && cfg_wr_i && (cfg_addr_i == `PPM_OFS_CSR);

  // power-state sequencing and loader control
  always_comb begin
    next_st      = st;
    next_ps      = ps;
    next_widx    = widx;
    next_ee_go   = 1'b0;
    next_ee_busy = ee_busy;
    next_lcnt    = lcnt;
    next_wcnt    = 8'h00;
    next_scnt    = scnt;
    next_ven     = ven;
    next_dev     = dev;
    next_cls     = cls;
    next_sven    = sven;
    next_sid     = sid;
    next_user_w  = user_w;
    // budget counted from reset release, strap cycles included
    next_lcnt = lcnt + 17'd1;
    unique case (st)
      PPM_ST_STRAP: begin
        // strap sampled after the synchroniser settles
        next_scnt = scnt + 2'h1;
        if (scnt == `PPM_SYNC_CYC) begin
          next_st = cs_s ? PPM_ST_LOAD : PPM_ST_D0U;
        end
      end
      PPM_ST_LOAD: begin
        if (!ee_busy) begin
          next_ee_go   = 1'b1;
          next_ee_busy = 1'b1;
        end
        if (ee_done) begin
          next_ee_busy = 1'b0;
          next_widx    = widx + 3'h1;
          unique case (widx)
            `PPM_EE_W_VEN:  next_ven = ee_data;
            `PPM_EE_W_DEV:  next_dev = ee_data;
            // only the upper byte is used
            `PPM_EE_W_CLO:  next_cls[7:0] = ee_data[15:8];
            `PPM_EE_W_CHI:  next_cls[23:8] = ee_data;
            `PPM_EE_W_SVEN: next_sven = ee_data;
            `PPM_EE_W_SID:  next_sid = ee_data;
            // user word loaded only from the eeprom
            `PPM_EE_W_ULO:  next_user_w[15:0] = ee_data;
            `PPM_EE_W_UHI:  next_user_w[31:16] = ee_data;
          endcase
          if (widx == `PPM_EE_WORDS) begin
            next_st = PPM_ST_D0U;
          end
        end
        // give up at the clock budget
        if (lcnt == LOAD_END) begin
          next_st      = PPM_ST_D0U;
          next_ee_busy = 1'b0;
        end
      end
      PPM_ST_D0U: begin
        if (mem_enable_i) begin
          next_st = PPM_ST_D0A;
        end
        if (ps_req(csr_wr, cfg_be_i, cfg_wdata_i[1:0], `PPM_PS_D3)) begin
          next_st = PPM_ST_D3;
          next_ps = `PPM_PS_D3;
        end
      end
      PPM_ST_D0A: begin
        if (ps_req(csr_wr, cfg_be_i, cfg_wdata_i[1:0], `PPM_PS_D3)) begin
          next_st = PPM_ST_D3;
          next_ps = `PPM_PS_D3;
        end
      end
      PPM_ST_D3: begin
        if (ps_req(csr_wr, cfg_be_i, cfg_wdata_i[1:0], `PPM_PS_D0)) begin
          next_st = PPM_ST_WAKE;
          next_ps = `PPM_PS_D0;
        end
      end
      PPM_ST_WAKE: begin
        next_wcnt = wcnt + 8'h01;
        if (wcnt == WAKE_END) begin
          next_st = PPM_ST_D0A;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st      <= PPM_ST_STRAP;
      ps      <= `PPM_PS_D0;
      widx    <= 3'h0;
      ee_go   <= 1'b0;
      ee_busy <= 1'b0;
      lcnt    <= 17'd0;
      wcnt    <= 8'h00;
      scnt    <= 2'h0;
      ven     <= VEN_DEF;
      dev     <= DEV_DEF;
      cls     <= `PPM_CLASS_RST;
      sven    <= 16'h0000;
      sid     <= 16'h0000;
      user_w  <= `PPM_USER_RST;
    end else begin
      st      <= next_st;
      ps      <= next_ps;
      widx    <= next_widx;
      ee_go   <= next_ee_go;
      ee_busy <= next_ee_busy;
      lcnt    <= next_lcnt;
      wcnt    <= next_wcnt;
      scnt    <= next_scnt;
      ven     <= next_ven;
      dev     <= next_dev;
      cls     <= next_cls;
      sven    <= next_sven;
      sid     <= next_sid;
      user_w  <= next_user_w;
    end
  end

  // configuration answers, event flags and gated outputs
  always_comb begin
    next_pme_en = pme_en;
    next_pme_st = pme_st;
    next_rdata  = rdata;
    next_ack    = 1'b0;
    next_retry  = 1'b0;
    if (csr_wr && cfg_be_i[1] && st != PPM_ST_LOAD && st != PPM_ST_STRAP) begin
      next_pme_en = cfg_wdata_i[`PPM_PME_EN_BIT];
    end
    if (csr_wr && cfg_be_i[1] && cfg_wdata_i[`PPM_PME_ST_BIT]) begin
      next_pme_st = 1'b0;
    end
    // set wins over clear, enable not needed
    if (st == PPM_ST_D3 && wake_evt) begin
      next_pme_st = 1'b1;
    end
    if (cfg_sel_i) begin
      if (st == PPM_ST_STRAP || st == PPM_ST_LOAD) begin
        next_retry = 1'b1;                   // busy loading, retry later
      end else begin
        next_ack   = 1'b1;
        next_rdata = 32'h00000000;
        if (!cfg_wr_i) begin
          unique case (cfg_addr_i)
            `PPM_OFS_CAP: next_rdata = {`PPM_PME_SUP, 7'h00, `PPM_PME_CLK,
                                        `PPM_PM_VER, `PPM_NEXT_PTR,
                                        `PPM_CAP_ID};
            `PPM_OFS_CSR: next_rdata = {16'h0000, pme_st, 6'h00, pme_en,
                                        6'h00, ps};
            `PPM_OFS_USER: next_rdata = user_w;
            default:      next_rdata = 32'h00000000;
          endcase
        end
      end
    end
    // event drives only from D3hot when enabled
    next_pme_oe = (st == PPM_ST_D3) && pme_en && next_pme_st;
    // memory answers and interrupt only when active
    next_mack   = mem_sel_i && (st == PPM_ST_D0A);
    next_inta_n = !(uart_irq_i && st == PPM_ST_D0A);
    // drivers off through the wake transition
    next_drv_en = (next_st != PPM_ST_WAKE);
  end

  // registered outputs and input synchronisers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pme_en   <= 1'b0;
      pme_st   <= 1'b0;
      pme_oe   <= 1'b0;
      rdata    <= 32'h00000000;
      ack      <= 1'b0;
      retry    <= 1'b0;
      mack     <= 1'b0;
      inta_n   <= 1'b1;
      drv_en   <= 1'b1;
      rx_m     <= 4'hf;
      rx_s     <= 4'hf;
      rx_d     <= 4'hf;
      cs_m     <= 1'b0;
      cs_s     <= 1'b0;
      msr_d    <= 16'h0000;
    end else begin
      pme_en   <= next_pme_en;
      pme_st   <= next_pme_st;
      pme_oe   <= next_pme_oe;
      rdata    <= next_rdata;
      ack      <= next_ack;
      retry    <= next_retry;
      mack     <= next_mack;
      inta_n   <= next_inta_n;
      drv_en   <= next_drv_en;
      rx_m     <= rx_pin_i;
      rx_s     <= rx_m;
      rx_d     <= rx_s;
      cs_m     <= eeprom_chip_select_i;
      cs_s     <= cs_m;
      msr_d    <= msr_delta_i;
    end
  end

  // receive path never stopped by the power state
  assign rx_run_o      = 1'b1;
  assign cfg_rdata_o   = rdata;
  assign cfg_ack_o     = ack;
  assign cfg_retry_o   = retry;
  assign mem_ack_o     = mack;
  assign inta_n_o      = inta_n;
  assign pci_drv_en_o  = drv_en;
  assign pme_out_o     = 1'b0;                // open drain, pulls low only
  assign pme_oe_o      = pme_oe;
  assign power_state_o = ps;
  assign vendor_id_o   = ven;
  assign device_id_o   = dev;
  assign class_code_o  = cls;
  assign subsys_ven_o  = sven;
  assign subsys_id_o   = sid;
endmodule : ppm_pm_top

// ---- tb/ppm_pm_monitor.sv ----
// assertion checker for the power-management block
`timescale 1ns/10ps
module ppm_pm_monitor (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        cfg_sel_i,
  input wire logic        cfg_wr_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_ack_o,
  input wire logic        cfg_retry_o,
  input wire logic        mem_sel_i,
  input wire logic        mem_ack_o,
  input wire logic        inta_n_o,
  input wire logic        pci_drv_en_o,
  input wire logic        rx_run_o,
  input wire logic        pme_oe_o,
  input wire logic [1:0]  power_state_o,
  input wire logic        eeprom_chip_select_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // every request gets exactly one answer next cycle
  property p_cfg_answer;
    cfg_sel_i |=> (cfg_ack_o ^ cfg_retry_o);
  endproperty
  a_cfg_answer: assert property (p_cfg_answer)
    else $error("config request not answered once");
  property p_cap;
    (cfg_sel_i && !cfg_wr_i && cfg_addr_i == 8'h40)
      |=> (cfg_retry_o || cfg_rdata_o == 32'h400a0001);
  endproperty
  a_cap: assert property (p_cap)
    else $error("capability word wrong");
  property p_csr_zero;
    (cfg_sel_i && !cfg_wr_i && cfg_addr_i == 8'h44)
      |=> (cfg_retry_o || (cfg_rdata_o & 32'hffff7efc) == 32'h0);
  endproperty
  a_csr_zero: assert property (p_csr_zero)
    else $error("unused control bits not zero");
  property p_ps_legal;
    power_state_o == 2'h0 || power_state_o == 2'h3;
  endproperty
  a_ps_legal: assert property (p_ps_legal)
    else $error("unsupported power state held");
  property p_mem_d3;
    (power_state_o == 2'h3 && mem_sel_i) |=> !mem_ack_o;
  endproperty
  a_mem_d3: assert property (p_mem_d3)
    else $error("memory answered in low power");
  property p_irq_d3;
    (power_state_o == 2'h3 && $past(power_state_o) == 2'h3) |-> inta_n_o;
  endproperty
  a_irq_d3: assert property (p_irq_d3)
    else $error("interrupt raised in low power");
  property p_pme_d3;
    $rose(pme_oe_o) |-> power_state_o == 2'h3;
  endproperty
  a_pme_d3: assert property (p_pme_d3)
    else $error("event raised outside low power");
  property p_wake_off;
    ($past(power_state_o) == 2'h3 && power_state_o == 2'h0)
      |-> !pci_drv_en_o [*8] ##1 !pci_drv_en_o [*2] ##1 pci_drv_en_o;
  endproperty
  a_wake_off: assert property (p_wake_off)
    else $error("bus drivers wrong during wake");
  property p_rx_run;
    rx_run_o;
  endproperty
  a_rx_run: assert property (p_rx_run)
    else $error("receive path stopped");
  c_wake: cover property ($rose(pme_oe_o));
  c_load: cover property ($fell(eeprom_chip_select_oe_o));
  c_exit: cover property ($past(power_state_o) == 2'h3 && power_state_o == 2'h0);
endmodule : ppm_pm_monitor
bind ppm_pm_top ppm_pm_monitor mon_u (.*);

// ---- tb/ppm_ee_model.sv ----
// serial eeprom model answering three-wire word reads
`timescale 1ns/10ps
module ppm_ee_model (
  input  wire logic cs_i,
  input  wire logic sk_i,
  input  wire logic di_i,
  output logic      do_o
);
  int          cnt;
  logic [8:0]  cmd;
  logic [15:0] sh;
  initial begin
    cnt = 0;
    cmd = '0;
    sh = '0;
    do_o = 1'b1;
  end
  // new frame on select; a released line flips
  always @(cs_i) begin
    cnt = 0;
    if (!cs_i) do_o = ~do_o;
  end
  always @(posedge sk_i) begin
    if (cs_i) begin
      cnt++;
      if (cnt <= 9) cmd = {cmd[7:0], di_i};
      if (cnt == 9 && cmd[8:6] == 3'b110)
        sh = 16'h5a00 + {10'h0, cmd[5:0]};
      if (cnt >= 10 && cnt <= 25) begin
        do_o <= #20 sh[15];
        sh = sh << 1;
      end else if (cnt > 25) begin
        do_o <= #20 ~do_o; // hold time over
      end
    end
  end
endmodule : ppm_ee_model

// ---- tb/test_pci_power_mgmt_config_loader.sv ----
// testbench for the power-management and loader block
`timescale 1ns/10ps
`include "ppm_cfg.svh"
module test_pci_power_mgmt_config_loader;
  logic        clk, rst_n, sel, wr, msel, men, irq, strap;
  logic        ack, rty, mack, inta_n, drv, rxr, pme_o, pme_oe;
  logic        cs_o, cs_oe, sk, di, edo, g_ack, g_rty;
  logic [7:0]  adr;
  logic [3:0]  be, rx;
  logic [31:0] wd, rd, rdata;
  logic [15:0] modem_line_status_register, ven, dev, sven, sid;
  logic [23:0] cls;
  logic [1:0]  ps;
  int          failures, checked;
  wire         cs_w = cs_oe ? cs_o : strap;
  ppm_pm_top #(.LOAD_LIMIT(4000), .SK_HALF(8'h04),
    .VEN_DEF(16'h1234), .DEV_DEF(16'h4321)) dut_u ( // arbitrary ids
    .sys_clk_i(clk), .rst_n_i(rst_n), .cfg_sel_i(sel), .cfg_wr_i(wr),
    .cfg_addr_i(adr), .cfg_be_i(be), .cfg_wdata_i(wd),
    .cfg_rdata_o(rdata), .cfg_ack_o(ack), .cfg_retry_o(rty),
    .mem_sel_i(msel), .mem_ack_o(mack), .mem_enable_i(men),
    .uart_irq_i(irq), .inta_n_o(inta_n), .pci_drv_en_o(drv),
    .rx_run_o(rxr), .rx_pin_i(rx), .msr_delta_i(modem_line_status_register), .pme_out_o(pme_o),
    .pme_oe_o(pme_oe), .power_state_o(ps), .vendor_id_o(ven),
    .device_id_o(dev), .class_code_o(cls), .subsys_ven_o(sven),
    .subsys_id_o(sid), .eeprom_chip_select_i(cs_w),
    .eeprom_chip_select_o(cs_o), .eeprom_chip_select_oe_o(cs_oe),
    .ee_sk_o(sk), .ee_di_o(di), .ee_do_i(edo));
  ppm_ee_model ee_u (.cs_i(cs_w), .sk_i(sk), .di_i(di), .do_o(edo));
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one config access; answer sampled on the next edge
  task automatic cfg(input logic w, input logic [7:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    #2;
    sel = 1'b1;
    wr = w;
    adr = a;
    be = b;
    wd = d;
    @(posedge clk);
    #2;
    sel = 1'b0;
    g_ack = ack;
    g_rty = rty;
    rd = rdata;
  endtask : cfg
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    cfg(1'b0, a, 4'hf, 32'h0);
    chk(g_ack, 1'b1);
    chk(rd, e);
  endtask : rdc
  task automatic mem(input logic e);
    @(posedge clk);
    #2;
    msel = 1'b1;
    @(posedge clk);
    #2;
    msel = 1'b0;
    chk(mack, e);
  endtask : mem
  task automatic rst(input logic s);
    strap = s;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #2;
    rst_n = 1'b1;
  endtask : rst
  // clear status, write enable from en, raise one wake source in low power
  task automatic wake(input logic en, input logic use_rx);
    cfg(1'b1, 8'h44, 4'h2, {16'h0, 7'h40, en, 8'h0});
    @(posedge clk);
    #2;
    if (use_rx) rx = 4'hd;
    else modem_line_status_register = 16'h0100;
    repeat (8) @(posedge clk);
    #2;
    rx = 4'hf;
    modem_line_status_register = 16'h0;
    chk(pme_oe, en);
    rdc(8'h44, {16'h0, 7'h40, en, 8'h3});
  endtask : wake
  initial begin
    {sel, wr, msel, men, irq, strap} = 6'h0;
    rst_n = 1'b0;
    adr = 8'h0;
    be = 4'h0;
    wd = 32'h0;
    rx = 4'hf;
    modem_line_status_register = 16'h0;
    failures = 0;
    checked = 0;
    rst(1'b0);
    repeat (5) @(posedge clk);
    chk({ven, dev}, 32'h12344321);
    chk({8'h0, cls}, {8'h0, `PPM_CLASS_RST});
    rdc(8'h40, 32'h400a0001);
    rdc(8'h44, 32'h0);
    cfg(1'b1, 8'h48, 4'hf, 32'hffffffff);
    cfg(1'b1, 8'h40, 4'hf, 32'h0);
    rdc(8'h48, 32'h0);
    rdc(8'h40, 32'h400a0001);
    rdc(8'h4c, 32'h0);
    mem(1'b0);
    men = 1'b1;
    irq = 1'b1;
    mem(1'b1);
    chk(inta_n, 1'b0);
    cfg(1'b1, 8'h44, 4'hf, 32'hffff0101);
    rdc(8'h44, 32'h100);
    for (int i = 1; i < 3; i++) begin
      cfg(1'b1, 8'h44, 4'h1, i);
      rdc(8'h44, 32'h100);
    end
    cfg(1'b1, 8'h44, 4'h1, 32'h3);
    rdc(8'h44, 32'h103);
    mem(1'b0);
    chk(inta_n, 1'b1);
    chk(rxr, 1'b1);
    // in low power: enabled wake by modem delta, then by start bit, then start bit with event disabled
    wake(1'b1, 1'b0);
    wake(1'b1, 1'b1);
    wake(1'b0, 1'b1);
    chk(pme_o, 1'b0);
    men = 1'b0;
    cfg(1'b1, 8'h44, 4'h1, 32'h0);
    chk({ps, drv}, 3'h0);
    repeat (8) @(posedge clk);
    chk(drv, 1'b0);
    repeat (3) @(posedge clk);
    chk(drv, 1'b1);
    mem(1'b1);
    rdc(8'h44, 32'h8000);
    cfg(1'b1, 8'h44, 4'h2, 32'h8000);
    rdc(8'h44, 32'h0);
    rst(1'b1);
    cfg(1'b0, 8'h48, 4'hf, 32'h0);
    chk(g_rty, 1'b1);
    for (int i = 0; i < 2100 && g_ack !== 1'b1; i++)
      cfg(1'b0, 8'h48, 4'hf, 32'h0);
    chk(g_ack, 1'b1);
    chk(rd, 32'h5a075a06);
    chk({ven, dev}, 32'h5a005a01);
    chk({8'h0, cls}, 32'h005a035a);
    chk({sven, sid}, 32'h5a045a05);
    rdc(8'h44, 32'h0);
    mem(1'b0);
    finish_test;
  end
  // watchdog
  initial begin
    #2000000;
    failures++;
    finish_test;
  end
endmodule : test_pci_power_mgmt_config_loader
